// file: src/dmacc_pkg.sv
// shared constants, register map and types of the dma channel controller
package dmacc_pkg;

  localparam int DMACC_DATA_W = 32;
  localparam int DMACC_LEN_W = 16;
  localparam int DMACC_PRIO_W = 3;
  localparam int DMACC_WIDTH_W = 2;
  localparam int DMACC_CH_SHIFT = 5;

  // per-channel register offsets inside a channel's window
  localparam logic [DMACC_CH_SHIFT-1:0] OFS_A_START = 5'h00;
  localparam logic [DMACC_CH_SHIFT-1:0] OFS_B_START = 5'h04;
  localparam logic [DMACC_CH_SHIFT-1:0] OFS_ITEM_LENGTH = 5'h08;
  localparam logic [DMACC_CH_SHIFT-1:0] OFS_CHANNEL_CONTROL = 5'h0c;
  localparam logic [DMACC_CH_SHIFT-1:0] OFS_ITEM_INDEX = 5'h10;
  localparam logic [DMACC_CH_SHIFT-1:0] OFS_REQUEST_SOURCE_SELECT = 5'h14;

  // channel_control field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_WIDTH_LSB = 1;
  localparam int CTRL_TRIG_BIT = 3;
  localparam int CTRL_B_SIDE_INCREMENT_BIT = 4;
  localparam int CTRL_A_SIDE_INCREMENT_BIT = 5;
  localparam int CTRL_CIRC_BIT = 6;
  localparam int CTRL_PRIO_LSB = 7;

  // transfer_width codes
  localparam logic [DMACC_WIDTH_W-1:0] WIDTH_BYTE = 2'h0;
  localparam logic [DMACC_WIDTH_W-1:0] WIDTH_HALF = 2'h1;
  localparam logic [DMACC_WIDTH_W-1:0] WIDTH_WORD = 2'h2;
  localparam logic [DMACC_WIDTH_W-1:0] WIDTH_RSVD = 2'h3;

  localparam logic [DMACC_DATA_W-1:0] STEP_BYTE = 32'h00000001;
  localparam logic [DMACC_DATA_W-1:0] STEP_HALF = 32'h00000002;
  localparam logic [DMACC_DATA_W-1:0] STEP_WORD = 32'h00000004;
  localparam logic [DMACC_DATA_W-1:0] STEP_NONE = 32'h00000000;

  // reset values and the item index increment
  localparam logic [DMACC_DATA_W-1:0] RST_ADDR = 32'h00000000;
  localparam logic [DMACC_DATA_W-1:0] RST_DATA = 32'h00000000;
  localparam logic [DMACC_LEN_W-1:0] RST_LEN = 16'h0000;
  localparam logic [DMACC_LEN_W-1:0] IDX_ONE = 16'h0001;
  localparam logic [DMACC_PRIO_W-1:0] RST_PRIO = 3'h0;
  localparam logic [DMACC_WIDTH_W-1:0] RST_WIDTH = 2'h0;

  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_RDATA, ENG_WRITE} dmacc_eng_type;

  function automatic logic [DMACC_DATA_W-1:0] dmaccStep(input logic [DMACC_WIDTH_W-1:0] w);
    logic [DMACC_DATA_W-1:0] s;
    s = STEP_NONE;
    if (w == WIDTH_BYTE) begin
      s = STEP_BYTE;
    end else if (w == WIDTH_HALF) begin
      s = STEP_HALF;
    end else if (w == WIDTH_WORD) begin
      s = STEP_WORD;
    end
    return s;
  endfunction

endpackage

// file: src/dmacc_skid_buffer.sv
// small valid/ready buffer between bus read data and the write side
`timescale 1ns/10ps
module dmacc_skid_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic ready_q;
  wire push = inValid & ready_q;
  wire pop = outValid & outReady;

  assign count_d = count_q + CNT_W'(push) - CNT_W'(pop);
  assign inReady = ready_q;
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];

  // ready is registered so the source sees a clean flop; full is honest
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= (count_d != CNT_FULL);
      if (push) begin
        wrPtr_q <= (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + PTR_W'(1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule

// file: src/dmacc_top.sv
// multi-channel dma controller: channel registers, arbiter and copy engine
//
// Notes on behaviour
// - among active requesting channels the one with the largest 3-bit priority wins the bus, 000 lowest, 111 highest.
// - on equal priority the lower-numbered channel wins.
// - without wraparound the channel stops after its item count and clears its own enable bit.
// - with wraparound on a request-triggered channel, enable stays set and each run restarts from index zero.
// - with the B-side increment bit set the B address steps by the width's byte size, otherwise it stays fixed.
// - without request trigger an enabled channel runs at once, with it only while its selected peripheral requests.
// - width code 00 is one byte, 01 two bytes, 10 four bytes, 11 reserved.
// - a channel whose enable bit reads 0 is inactive and holds its state; writing 1 starts it.
// - clearing enable mid-transfer finishes the current read-write cycle first, and re-enabling is refused until stopped.
// - a length value of N moves N+1 items.
// - a read-only index counts items moved and clears at each new start and each wraparound restart.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module dmacc_top
  import dmacc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NREQ = 8,
  parameter int BUF_DEPTH = 2,
  localparam int CH_W = $clog2(NCH),
  localparam int SEL_W = $clog2(NREQ),
  localparam int ADDR_W = DMACC_CH_SHIFT + CH_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [DMACC_DATA_W-1:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [DMACC_DATA_W-1:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic [NREQ-1:0] periphReq,
  output logic memCmdValid,
  output logic memCmdWrite,
  output logic [DMACC_DATA_W-1:0] memAddr,
  output logic [DMACC_WIDTH_W-1:0] memSize,
  output logic [DMACC_DATA_W-1:0] memWdata,
  input wire logic memCmdReady,
  input wire logic memRdValid,
  output logic memRdReady,
  input wire logic [DMACC_DATA_W-1:0] memRdData
);

  // channel state
  logic [DMACC_DATA_W-1:0] aStart_q [NCH];
  logic [DMACC_DATA_W-1:0] bStart_q [NCH];
  logic [DMACC_DATA_W-1:0] aCur_q [NCH];
  logic [DMACC_DATA_W-1:0] bCur_q [NCH];
  logic [DMACC_LEN_W-1:0] len_q [NCH];
  logic [DMACC_LEN_W-1:0] idx_q [NCH];
  logic [DMACC_PRIO_W-1:0] prio_q [NCH];
  logic [DMACC_WIDTH_W-1:0] width_q [NCH];
  logic [SEL_W-1:0] reqSel_q [NCH];
  logic [NCH-1:0] on_q;
  logic [NCH-1:0] stopPend_q;
  logic [NCH-1:0] circ_q;
  logic [NCH-1:0] a_side_increment_q;
  logic [NCH-1:0] b_side_increment_q;
  logic [NCH-1:0] trig_q;

  // peripheral request synchroniser
  logic [NREQ-1:0] reqMeta_q;
  logic [NREQ-1:0] reqSync_q;

  // bus slave
  logic waitReq_q;
  logic [DMACC_DATA_W-1:0] readData_q;
  logic [DMACC_DATA_W-1:0] regRead;
  logic [DMACC_DATA_W-1:0] beMask;
  logic [DMACC_DATA_W-1:0] wVal;
  wire [CH_W-1:0] selCh = avsAddress[ADDR_W-1:DMACC_CH_SHIFT];
  wire [DMACC_CH_SHIFT-1:0] selOfs = avsAddress[DMACC_CH_SHIFT-1:0];
  wire busWrite = avsWrite & ~waitReq_q;
  wire busReadTake = avsRead & waitReq_q;

  // engine
  dmacc_eng_type state_q;
  logic [CH_W-1:0] cur_q;
  logic memCmdValid_q;
  logic memCmdWrite_q;
  logic [DMACC_DATA_W-1:0] memAddr_q;
  logic [DMACC_WIDTH_W-1:0] memSize_q;
  logic [DMACC_DATA_W-1:0] memWdata_q;
  logic [NCH-1:0] chReq;
  logic winFound;
  logic [CH_W-1:0] winIdx;
  logic [DMACC_PRIO_W-1:0] winPrio;
  logic bufOutValid;
  logic [DMACC_DATA_W-1:0] bufOutData;
  wire bufPop = (state_q == ENG_RDATA) & bufOutValid;
  wire wrDone = (state_q == ENG_WRITE) & memCmdReady;
  wire lastItem = (idx_q[cur_q] == len_q[cur_q]);
  wire wrapRun = circ_q[cur_q] & trig_q[cur_q];
  // a channel granted in this very cycle is already busy, so a clear must wait for its write
  wire engBusy = (state_q != ENG_IDLE) | winFound;
  wire [CH_W-1:0] busyCh = (state_q == ENG_IDLE) ? winIdx : cur_q;

  assign avsReaddata = readData_q;
  assign avsWaitrequest = waitReq_q;
  assign memCmdValid = memCmdValid_q;
  assign memCmdWrite = memCmdWrite_q;
  assign memAddr = memAddr_q;
  assign memSize = memSize_q;
  assign memWdata = memWdata_q;

  assign beMask = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}}, {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
  assign wVal = (regRead & ~beMask) | (avsWritedata & beMask);

  // read mux; unmapped offsets read zero
  always_comb begin
    regRead = RST_DATA;
    if (selOfs == OFS_A_START) begin
      regRead = aStart_q[selCh];
    end else if (selOfs == OFS_B_START) begin
      regRead = bStart_q[selCh];
    end else if (selOfs == OFS_ITEM_LENGTH) begin
      regRead = DMACC_DATA_W'(len_q[selCh]);
    end else if (selOfs == OFS_CHANNEL_CONTROL) begin
      regRead = DMACC_DATA_W'({prio_q[selCh], circ_q[selCh], a_side_increment_q[selCh], b_side_increment_q[selCh],
                               trig_q[selCh], width_q[selCh], on_q[selCh]});
    end else if (selOfs == OFS_ITEM_INDEX) begin
      regRead = DMACC_DATA_W'(idx_q[selCh]);
    end else if (selOfs == OFS_REQUEST_SOURCE_SELECT) begin
      regRead = DMACC_DATA_W'(reqSel_q[selCh]);
    end
  end

  // a channel asks for the bus only when on, not stopping and width legal
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chReq[i] = on_q[i] & ~stopPend_q[i] & (width_q[i] != WIDTH_RSVD)
                 & (~trig_q[i] | reqSync_q[reqSel_q[i]]);
    end
  end

  // ascending scan with strict compare keeps the lower channel on ties
  always_comb begin
    winFound = 1'b0;
    winIdx = '0;
    winPrio = RST_PRIO;
    for (int i = 0; i < NCH; i++) begin
      if (chReq[i] && (!winFound || prio_q[i] > winPrio)) begin
        winFound = 1'b1;
        winIdx = CH_W'(i);
        winPrio = prio_q[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reqMeta_q <= '0;
      reqSync_q <= '0;
    end else begin
      reqMeta_q <= periphReq;
      reqSync_q <= reqMeta_q;
    end
  end

  // one-cycle waitrequest low answers every access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      waitReq_q <= 1'b1;
      readData_q <= RST_DATA;
    end else begin
      waitReq_q <= ~((avsRead | avsWrite) & waitReq_q);
      if (busReadTake) begin
        readData_q <= regRead;
      end
    end
  end

  // channel registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        aStart_q[i] <= RST_ADDR;
        bStart_q[i] <= RST_ADDR;
        aCur_q[i] <= RST_ADDR;
        bCur_q[i] <= RST_ADDR;
        len_q[i] <= RST_LEN;
        idx_q[i] <= RST_LEN;
        prio_q[i] <= RST_PRIO;
        width_q[i] <= RST_WIDTH;
        reqSel_q[i] <= '0;
      end
      on_q <= '0;
      stopPend_q <= '0;
      circ_q <= '0;
      a_side_increment_q <= '0;
      b_side_increment_q <= '0;
      trig_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (busWrite && selCh == CH_W'(i)) begin
          if (selOfs == OFS_A_START) begin
            aStart_q[i] <= wVal;
          end else if (selOfs == OFS_B_START) begin
            bStart_q[i] <= wVal;
          end else if (selOfs == OFS_ITEM_LENGTH) begin
            len_q[i] <= wVal[DMACC_LEN_W-1:0];
          end else if (selOfs == OFS_REQUEST_SOURCE_SELECT) begin
            reqSel_q[i] <= wVal[SEL_W-1:0];
          end else if (selOfs == OFS_CHANNEL_CONTROL) begin
            prio_q[i] <= wVal[CTRL_PRIO_LSB +: DMACC_PRIO_W];
            circ_q[i] <= wVal[CTRL_CIRC_BIT];
            a_side_increment_q[i] <= wVal[CTRL_A_SIDE_INCREMENT_BIT];
            b_side_increment_q[i] <= wVal[CTRL_B_SIDE_INCREMENT_BIT];
            trig_q[i] <= wVal[CTRL_TRIG_BIT];
            width_q[i] <= wVal[CTRL_WIDTH_LSB +: DMACC_WIDTH_W];
            if (wVal[CTRL_ON_BIT]) begin
              // a 1 while still on or stopping leaves enable, index and current addresses unchanged
              if (!on_q[i]) begin
                on_q[i] <= 1'b1;
                idx_q[i] <= RST_LEN;
                aCur_q[i] <= aStart_q[i];
                bCur_q[i] <= bStart_q[i];
              end
            end else if (on_q[i]) begin
              if (engBusy && busyCh == CH_W'(i)) begin
                stopPend_q[i] <= 1'b1;
              end else begin
                on_q[i] <= 1'b0;
              end
            end
          end
        end
        // item finished: a same-cycle software clear also stops the channel here
        if (wrDone && cur_q == CH_W'(i)) begin
          aCur_q[i] <= aCur_q[i] + (a_side_increment_q[i] ? dmaccStep(width_q[i]) : STEP_NONE);
          bCur_q[i] <= bCur_q[i] + (b_side_increment_q[i] ? dmaccStep(width_q[i]) : STEP_NONE);
          idx_q[i] <= idx_q[i] + IDX_ONE;
          if (lastItem && wrapRun) begin
            idx_q[i] <= RST_LEN;
            aCur_q[i] <= aStart_q[i];
            bCur_q[i] <= bStart_q[i];
          end
          if ((lastItem && !wrapRun) || stopPend_q[i] ||
              (busWrite && selCh == CH_W'(i) && selOfs == OFS_CHANNEL_CONTROL && !wVal[CTRL_ON_BIT])) begin
            on_q[i] <= 1'b0;
            stopPend_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // copy engine: read A, park data in the buffer, write B
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ENG_IDLE;
      cur_q <= '0;
      memCmdValid_q <= 1'b0;
      memCmdWrite_q <= 1'b0;
      memAddr_q <= RST_ADDR;
      memSize_q <= RST_WIDTH;
      memWdata_q <= RST_DATA;
    end else begin
      case (state_q)
        ENG_IDLE: begin
          if (winFound) begin
            cur_q <= winIdx;
            memCmdValid_q <= 1'b1;
            memCmdWrite_q <= 1'b0;
            memAddr_q <= aCur_q[winIdx];
            memSize_q <= width_q[winIdx];
            state_q <= ENG_READ;
          end
        end
        ENG_READ: begin
          if (memCmdReady) begin
            memCmdValid_q <= 1'b0;
            state_q <= ENG_RDATA;
          end
        end
        ENG_RDATA: begin
          if (bufOutValid) begin
            memCmdValid_q <= 1'b1;
            memCmdWrite_q <= 1'b1;
            memAddr_q <= bCur_q[cur_q];
            memWdata_q <= bufOutData;
            state_q <= ENG_WRITE;
          end
        end
        ENG_WRITE: begin
          // a stop request for the busy channel is only honoured here, after the write lands
          if (memCmdReady) begin
            memCmdValid_q <= 1'b0;
            memCmdWrite_q <= 1'b0;
            state_q <= ENG_IDLE;
          end
        end
        default: begin
          state_q <= ENG_IDLE;
        end
      endcase
    end
  end

  dmacc_skid_buffer #(
    .WIDTH(DMACC_DATA_W),
    .DEPTH(BUF_DEPTH)
  ) readBuffer (
    .mclk(mclk),
    .rstn(rstn),
    .inValid(memRdValid),
    .inReady(memRdReady),
    .inData(memRdData),
    .outValid(bufOutValid),
    .outReady(bufPop),
    .outData(bufOutData)
  );

endmodule

// file: testbench/dmacc_top_chk.sv
// port checker for the dma controller, bound to its top
`timescale 1ns/10ps
module dmacc_top_chk
  import dmacc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NREQ = 8,
  localparam int AW = DMACC_CH_SHIFT + $clog2(NCH)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [AW-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [DMACC_DATA_W-1:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic [DMACC_DATA_W-1:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic [NREQ-1:0] periphReq,
  input wire logic memCmdValid,
  input wire logic memCmdWrite,
  input wire logic [DMACC_DATA_W-1:0] memAddr,
  input wire logic [DMACC_WIDTH_W-1:0] memSize,
  input wire logic [DMACC_DATA_W-1:0] memWdata,
  input wire logic memCmdReady,
  input wire logic memRdValid,
  input wire logic memRdReady,
  input wire logic [DMACC_DATA_W-1:0] memRdData
);
  logic flight_q;
  logic [DMACC_DATA_W-1:0] rdWord_q;
  // one item in flight: a read opens it, the paired write closes it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flight_q <= 1'b0;
      rdWord_q <= RST_DATA;
    end else begin
      if (memCmdValid && memCmdReady) flight_q <= !memCmdWrite;
      if (memRdValid && memRdReady) rdWord_q <= memRdData;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_width_legal: assert property (memCmdValid |-> memSize != WIDTH_RSVD)
    else $error("reserved width on bus");
  a_cmd_hold: assert property (memCmdValid && !memCmdReady |=> memCmdValid && $stable(memAddr)
    && $stable(memWdata) && $stable(memCmdWrite)) else $error("command changed before accept");
  a_read_first: assert property (memCmdValid && memCmdWrite |-> flight_q)
    else $error("write without read");
  a_one_flight: assert property (memCmdValid && !memCmdWrite |-> !flight_q)
    else $error("read before write done");
  a_copy_word: assert property (memCmdValid && memCmdWrite |-> memWdata == rdWord_q)
    else $error("written word differs from read");
  a_read_write: assert property (memRdValid && memRdReady |-> ##[1:4] (memCmdValid && memCmdWrite))
    else $error("no write after read data");
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("register access not answered");
  a_bus_single: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low too long");
  c_rd_taken: cover property (memRdValid && memRdReady);
  c_wr_taken: cover property (memCmdValid && memCmdReady && memCmdWrite);
  c_reg_write: cover property (avsWrite && !avsWaitrequest);
endmodule

bind dmacc_top dmacc_top_chk #(.NCH(NCH), .NREQ(NREQ)) i_dmacc_top_chk (.*);

// file: testbench/dmacc_mem_model.sv
// far-side memory bus answering the copy engine
`timescale 1ns/10ps
module dmacc_mem_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic memCmdValid,
  input wire logic memCmdWrite,
  input wire logic [31:0] memAddr,
  input wire logic memRdReady,
  output logic memCmdReady,
  output logic memRdValid,
  output logic [31:0] memRdData
);
  // read word derived from its address so every copy can be traced
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memCmdReady <= 1'b0;
      memRdValid <= 1'b0;
      memRdData <= 32'h0;
    end else begin
      memCmdReady <= slow ? !memCmdReady : 1'b1;
      if (memRdValid && memRdReady) begin
        memRdValid <= 1'b0;
        memRdData <= ~memRdData; // no stale word after hand-over
      end
      if (memCmdValid && memCmdReady && !memCmdWrite) begin
        memRdValid <= 1'b1;
        memRdData <= memAddr ^ 32'ha5a50000;
      end
    end
  end
endmodule

// file: testbench/dmacc_top_bench.sv
// self-checking bench for the dma controller
`timescale 1ns/10ps
module dmacc_top_bench;
  import dmacc_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] avsAddress = 7'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'hf;
  logic [7:0] periphReq = 8'h0;
  logic slow = 1'b0;
  logic avsWaitrequest, memCmdValid, memCmdWrite, memCmdReady, memRdValid, memRdReady;
  logic [31:0] avsReaddata, memAddr, memWdata, memRdData, q;
  logic [1:0] memSize;
  logic [31:0] wq[$];
  logic [31:0] dq[$];
  int fails = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  dmacc_top i_dmacc_top (.*);
  dmacc_mem_model i_dmacc_mem_model (.*);
  always @(posedge mclk) begin
    if (memCmdValid === 1'b1 && memCmdReady === 1'b1 && memCmdWrite === 1'b1) begin
      wq.push_back(memAddr);
      dq.push_back(memWdata);
    end
  end
  task automatic end_of_test();
    $display("counts: %0d compared, %0d failed", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic acc(input logic wr, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge mclk);
    while (avsWaitrequest !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 20) begin
      chk(32'h1, 32'h0, "bus timeout");
      end_of_test();
    end
  endtask
  function automatic logic [6:0] ra(input int ch, input logic [4:0] o);
    return {ch[1:0], o};
  endfunction
  function automatic logic [31:0] cv(input logic [2:0] p, input logic c, a, b, t, input logic [1:0] w);
    return {22'h0, p, c, a, b, t, w, 1'b1};
  endfunction
  task automatic waitoff(input int ch);
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 400) begin
      acc(1'b0, ra(ch, OFS_CHANNEL_CONTROL), 32'h0);
      n++;
    end
    if (n >= 400) begin
      chk(32'h1, 32'h0, "stop timeout");
      end_of_test();
    end
  endtask
  task automatic setch(input int ch, input logic [31:0] a, b, n);
    wq.delete();
    dq.delete();
    acc(1'b1, ra(ch, OFS_A_START), a);
    acc(1'b1, ra(ch, OFS_B_START), b);
    acc(1'b1, ra(ch, OFS_ITEM_LENGTH), n);
    acc(1'b1, ra(ch, OFS_REQUEST_SOURCE_SELECT), 32'(ch));
  endtask
  // two request-triggered channels raised in the same cycle
  task automatic race(input int x, y, input logic [2:0] px, py, input logic [31:0] first);
    setch(x, 32'h10, 32'h300, 32'h0);
    setch(y, 32'h20, 32'h310, 32'h0);
    acc(1'b1, ra(x, OFS_CHANNEL_CONTROL), cv(px, 1'b0, 1'b0, 1'b0, 1'b1, WIDTH_WORD));
    acc(1'b1, ra(y, OFS_CHANNEL_CONTROL), cv(py, 1'b0, 1'b0, 1'b0, 1'b1, WIDTH_WORD));
    repeat (10) @(posedge mclk);
    chk(32'(wq.size()), 32'h0, "moved without request");
    periphReq <= (8'h1 << x) | (8'h1 << y);
    waitoff(x);
    waitoff(y);
    periphReq <= 8'h0;
    chk(wq[0], first, "grant order");
    $display("test race %0d %0d done", x, y);
  endtask
  initial begin
    #2500000;
    chk(32'h1, 32'h0, "run timeout");
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    acc(1'b0, ra(0, OFS_CHANNEL_CONTROL), 32'h0);
    chk(q, 32'h0, "control reset");
    acc(1'b1, ra(1, 5'h18), 32'hffffffff);
    acc(1'b0, ra(1, 5'h18), 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("test registers done");
    for (int w = 0; w < 3; w++) begin
      setch(0, 32'h100, 32'h200, 32'h2);
      acc(1'b1, ra(0, OFS_CHANNEL_CONTROL), cv(3'h0, 1'b0, 1'b0, 1'b1, 1'b0, w[1:0]));
      waitoff(0);
      acc(1'b0, ra(0, OFS_ITEM_INDEX), 32'h0);
      chk(q, 32'h3, "index after run");
      chk(32'(wq.size()), 32'h3, "item count");
      chk(wq[2], 32'h200 + (STEP_BYTE << w) * 2, "b step");
      chk(dq[2], 32'h100 ^ 32'ha5a50000, "a fixed");
    end
    $display("test widths done");
    slow <= 1'b1;
    setch(1, 32'h400, 32'h800, 32'h1);
    acc(1'b1, ra(1, OFS_CHANNEL_CONTROL), cv(3'h0, 1'b0, 1'b1, 1'b1, 1'b0, WIDTH_HALF));
    waitoff(1);
    chk(dq[1], 32'h402 ^ 32'ha5a50000, "a step");
    chk(wq[1], 32'h802, "b step half");
    $display("test stepping done");
    slow <= 1'b0;
    race(0, 1, 3'h0, 3'h7, 32'h310);
    race(2, 3, 3'h5, 3'h5, 32'h300);
    setch(0, 32'h40, 32'h600, 32'h1);
    acc(1'b1, ra(0, OFS_CHANNEL_CONTROL), cv(3'h0, 1'b1, 1'b0, 1'b1, 1'b1, WIDTH_BYTE));
    periphReq <= 8'h01;
    repeat (60) @(posedge mclk);
    periphReq <= 8'h00;
    repeat (10) @(posedge mclk);
    acc(1'b0, ra(0, OFS_CHANNEL_CONTROL), 32'h0);
    chk(32'(q[0]), 32'h1, "wrap keeps enable");
    chk(wq[2], 32'h600, "wrap restarts");
    acc(1'b1, ra(0, OFS_CHANNEL_CONTROL), 32'h0);
    waitoff(0);
    $display("test wraparound done");
    slow <= 1'b1;
    setch(3, 32'h1000, 32'h2000, 32'hff);
    acc(1'b1, ra(3, OFS_CHANNEL_CONTROL), cv(3'h2, 1'b0, 1'b1, 1'b1, 1'b0, WIDTH_WORD));
    repeat (30) @(posedge mclk);
    acc(1'b1, ra(3, OFS_CHANNEL_CONTROL), 32'h0);
    waitoff(3);
    acc(1'b0, ra(3, OFS_ITEM_INDEX), 32'h0);
    chk(32'(wq.size()), q, "items match index");
    chk(32'(wq.size() < 256), 32'h1, "stopped early");
    chk(dq[$], (wq[$] - 32'h1000) ^ 32'ha5a50000, "last item whole");
    acc(1'b1, ra(3, OFS_ITEM_LENGTH), 32'h0);
    acc(1'b1, ra(3, OFS_CHANNEL_CONTROL), cv(3'h2, 1'b0, 1'b1, 1'b1, 1'b0, WIDTH_WORD));
    waitoff(3);
    acc(1'b0, ra(3, OFS_ITEM_INDEX), 32'h0);
    chk(q, 32'h1, "index cleared on start");
    $display("test stop done");
    end_of_test();
  end
endmodule
